/* dv/host_model.sv */
// Purpose: host controller model on the link side of the front end
// Assumes: the bench queues bytes, link signals are sampled on clk
// Notes: slow mode stalls tx_ready at random for back-pressure
`timescale 1ns/1ps
`default_nettype none
module host_model
	import front_end_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic rx_ready,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_end,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_end,
	output logic tx_ready
);
	in_byte_t send_q[$];
	in_byte_t got_q[$];
	logic slow = 1'b0;
	logic took = 1'b0;
	initial {rx_valid, rx_end, rx_data, tx_ready} = 11'h001;
	// Capture at the sampling edge; an offered byte is held until taken
	always @(posedge clk) begin
		took = rx_valid && rx_ready;
		if (tx_valid && tx_ready) got_q.push_back('{tx_end, tx_data});
	end
	// Idle data inverts so a stale byte never passes for a fresh one
	always @(negedge clk) begin
		if (took) void'(send_q.pop_front());
		rx_valid = rst_n && send_q.size() > 0;
		{rx_end, rx_data} = rx_valid ? send_q[0] : {1'b0, ~rx_data};
		tx_ready = slow ? 1'($urandom % 2) : 1'b1;
	end
endmodule
`default_nettype wire

/* dv/remote_command_front_end_tb.sv */
// Purpose: self-checking bench of the remote command front end
// Assumes: host model on the link, command executor modelled here
// Notes: channel picks are random from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module remote_command_front_end_tb;
	import front_end_pkg::*;
	localparam int NCH = 4;
	localparam int WV[3] = '{5, -7, 2047};
	localparam logic [7:0] BIN[4] = '{8'h12, 8'h34, 8'hAB, 8'hCD};
	logic clk, rst_n, link_parallel, addressable, talk_en, rx_valid, rx_end, rx_ready;
	logic tx_valid, tx_end, tx_ready, arg_valid, cmd_start, op_complete, resp_ready_out;
	logic wave_def_start, warn_len, point_valid, cmd_error, exec_error, query_error;
	logic [7:0] rx_data, tx_data, arg_byte, channel;
	logic [15:0] exist_len, wave_len, edit_first, edit_last;
	logic [95:0] id_str;
	logic [1:0] query_code;
	cmd_class_t cmd_class;
	point_t point;
	logic cmd_done = 1'b0, resp_valid_in = 1'b0, resp_last_in = 1'b0;
	logic [7:0] resp_data_in = 8'h00;
	logic [7:0] resp_q[$];
	point_t pts[$];
	bit busy, is_q, took, full_seen;
	bit [31:0] args;
	int errors, check_count, ops, starts, defs, warns, cerrs, xerrs, qerrs, wait_n;
	remote_command_front_end #(.MAX_CH(NCH)) remote_command_front_end_i (.clk, .rst_n,
		.link_parallel, .addressable, .rx_valid, .rx_data, .rx_end, .rx_ready, .talk_en,
		.tx_valid, .tx_data, .tx_end, .tx_ready, .id_str, .cmd_class, .arg_valid, .arg_byte,
		.cmd_start, .cmd_done, .op_complete, .resp_valid_in, .resp_data_in, .resp_last_in,
		.resp_ready_out, .channel, .exist_len, .wave_def_start, .wave_len, .edit_first,
		.edit_last, .warn_len, .point_valid, .point, .cmd_error, .exec_error, .query_error,
		.query_code);
	host_model host_model_i (.clk, .rst_n, .rx_ready, .rx_valid, .rx_data, .rx_end,
		.tx_valid, .tx_data, .tx_end, .tx_ready);
	// Outside name decoder, as the executor would have it
	assign cmd_class = id_str == "SELCH" ? CLS_SEL_CH : id_str == "WDEFA" ? CLS_DEF_ASCII :
		id_str == "WDEFB" ? CLS_DEF_BIN : CLS_OTHER;
	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %0h seen %0h", name, exp, got);
		end
	endtask
	// Queue a message; mix scrambles letter case and sets bit 7 at random
	task automatic put(string s, bit end_last, bit mix);
		logic [7:0] b;
		for (int i = 0; i < s.len(); i++) begin
			b = s[i];
			if (mix && b >= "a" && b <= "z" && $urandom % 2) b = b - 8'h20;
			if (mix && $urandom % 2) b = b | 8'h80;
			host_model_i.send_q.push_back('{end_last && i == s.len() - 1, b});
		end
	endtask
	// Bounded wait until n completions and an idle link
	task automatic sync(int n);
		for (int t = 0; t < 5000; t++) begin
			if (ops >= n && host_model_i.send_q.size() == 0 && !busy && resp_q.size() == 0
				&& tx_valid !== 1'b1) break;
			@(negedge clk);
		end
		repeat (3) @(negedge clk);
		chk("op_complete_count", n, ops);
	endtask
	task automatic tx_is(string s, bit par);
		chk("tx_count", s.len(), host_model_i.got_q.size());
		foreach (host_model_i.got_q[i])
			if (i < s.len()) chk("tx_byte", {par && i == s.len() - 1, s[i]}, host_model_i.got_q[i]);
		host_model_i.got_q.delete();
	endtask
	task automatic stop_test;
		if (errors == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Event tally; a start while the previous one is unfinished is an error
	always @(posedge clk) begin
		took = resp_valid_in && resp_ready_out;
		ops += op_complete === 1'b1;
		defs += wave_def_start === 1'b1;
		warns += warn_len === 1'b1;
		cerrs += cmd_error === 1'b1;
		xerrs += exec_error === 1'b1;
		qerrs += query_error === 1'b1;
		if (rx_ready === 1'b0) full_seen = 1'b1;
		if (point_valid === 1'b1) pts.push_back(point);
		if (arg_valid === 1'b1) args = {args[23:0], arg_byte};
		if (cmd_start === 1'b1) begin
			chk("command_overlap", 0, busy || resp_q.size() > 0 || tx_valid === 1'b1);
			starts++;
			busy = 1'b1;
			wait_n = 1 + $urandom % 4;
			is_q = id_str == "QRY";
		end
	end
	// Executor: random delay; a query's answer is offered with cmd_done
	always @(negedge clk) begin
		cmd_done = 1'b0;
		if (took) void'(resp_q.pop_front());
		if (busy) wait_n--;
		if (busy && wait_n == 0) begin
			busy = 1'b0;
			cmd_done = 1'b1;
			if (is_q) resp_q = '{8'h41, 8'h42};
		end
		resp_valid_in = resp_q.size() > 0;
		resp_data_in = resp_valid_in ? resp_q[0] : ~resp_data_in;
		resp_last_in = resp_q.size() == 1;
	end
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Whole run is a few thousand cycles; 50k cycles means a hang
	initial begin
		#500000;
		errors++;
		stop_test;
	end
	initial begin
		int c, e, ch;
		{rst_n, link_parallel, addressable, talk_en} = 4'h0;
		exist_len = 16'h0004;
		void'($urandom(32'h2DF39741));
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk("channel", 8'h01, channel);
		ch = 1;
		// Random picks, some out of range, with white space and bit 7 noise
		for (int i = 0; i < 12; i++) begin
			c = $urandom % 7;
			e = xerrs;
			put($sformatf("\t selch %0d \n", c), 0, 1);
			sync(ops + 1);
			if (c >= 1 && c <= NCH) ch = c;
			chk("channel", ch, channel);
			chk("exec_error", c < 1 || c > NCH, xerrs - e);
		end
		put("selch 1;selch 4\n", 0, 0);
		sync(ops + 2);
		chk("channel", 4, channel);
		put("selch 2.5\n", 0, 0);
		sync(ops + 1);
		chk("channel", 3, channel);
		e = starts;
		put("sel ch 2\n", 0, 0);
		sync(ops + 1);
		chk("channel", 3, channel);
		chk("cmd_start", 1, starts - e);
		chk("arg_bytes", "CH2", args);
		put("qry\n", 0, 0);
		sync(ops + 1);
		tx_is("AB\r\n", 0);
		host_model_i.slow = 1'b1;
		put("qry;qry\n", 0, 1);
		sync(ops + 2);
		tx_is("AB\r\nAB\r\n", 0);
		host_model_i.slow = 1'b0;
		// Ascii definition: one point too many, length differs from existing
		e = defs;
		c = warns;
		put("wdefa w,3,5,-7,2047,9\n", 0, 0);
		sync(ops + 1);
		chk("wave_def", 1, defs - e);
		chk("wave_len", 3, wave_len);
		chk("edit_first", 0, edit_first);
		chk("edit_last", 2, edit_last);
		chk("warn_len", 1, warns - c);
		chk("points", 3, pts.size());
		foreach (pts[i]) chk("point", point_t'({16'(i), 16'(WV[i])}), pts[i]);
		exist_len = 16'h0002;
		e = xerrs;
		c = warns;
		put("wdefa w,2,-2049,-2048\n", 0, 0);
		sync(ops + 1);
		chk("exec_error", 1, xerrs - e);
		chk("warn_len", 0, warns - c);
		chk("point", point_t'({16'h0001, 16'hF800}), pts[$]);
		e = cerrs;
		c = defs;
		put("wdefb w,2,#14abcd;selch 2\n", 0, 0);
		sync(ops + 1);
		chk("cmd_error", 1, cerrs - e);
		chk("wave_def", 0, defs - c);
		chk("channel", 2, channel);
		// Flow control: 199 held bytes stay quiet, the 200th sends XOFF
		repeat (199) put(" ", 0, 0);
		sync(ops);
		chk("tx_count", 0, host_model_i.got_q.size());
		put(" ", 0, 0);
		sync(ops);
		put("\n", 0, 0);
		sync(ops);
		// Parser drains about 100 queued bytes before XON can go out
		repeat (250) @(negedge clk);
		tx_is(string'({CH_XOFF, CH_XON}), 0);
		// Response held by talk while empty messages fill the queue
		addressable = 1'b1;
		e = qerrs;
		put("qry\n", 0, 0);
		repeat (260) put("\n", 0, 0);
		for (int t = 0; t < 2000 && qerrs == e; t++) @(negedge clk);
		chk("query_error", 1, qerrs - e);
		chk("query_code", QERR_DEADLOCK, query_code);
		chk("queue_full", 1, full_seen);
		talk_en = 1'b1;
		sync(ops);
		// Let the full queue of newlines drain so XON lands before the mode change
		repeat (300) @(negedge clk);
		{talk_en, addressable} = 2'h0;
		tx_is(string'({CH_XOFF, CH_XON}), 0);
		link_parallel = 1'b1;
		for (int k = 1; k <= 3; k++) begin
			put($sformatf(k == 2 ? "selch %0d" : "selch %0d\n", k), k > 1, 0);
			sync(ops + 1);
			chk("channel", k, channel);
		end
		exist_len = 16'h0000;
		pts.delete();
		put("wdefb w,2,#14", 0, 0);
		foreach (BIN[i]) host_model_i.send_q.push_back('{i == 3, BIN[i]});
		sync(ops + 1);
		chk("wave_len", 2, wave_len);
		chk("points", 2, pts.size());
		foreach (pts[i]) chk("point", {16'(i), BIN[2 * i], BIN[2 * i + 1]}, pts[i]);
		// Parallel answer waits for talk; the next command waits with it
		put("qry;selch 4\n", 0, 0);
		repeat (60) @(negedge clk);
		chk("tx_count", 0, host_model_i.got_q.size());
		chk("channel", 3, channel);
		talk_en = 1'b1;
		sync(ops + 1);
		chk("channel", 4, channel);
		tx_is("AB\n", 1);
		stop_test;
	end
endmodule
`default_nettype wire

/* inc/front_end_pkg.sv */
// Purpose: shared constants and types of the remote command front end
// Assumes: 7-bit ASCII command stream, bytes from link logic on clk
// Notes: thresholds are queue fill levels in bytes
package front_end_pkg;
	localparam int QUEUE_DEPTH = 256;
	localparam int XOFF_LEVEL = 200;
	localparam int XON_FREE = 100;
	localparam int XON_LEVEL = XOFF_LEVEL - XON_FREE;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_SEMI = 8'h3B;
	localparam logic [7:0] CH_COMMA = 8'h2C;
	localparam logic [7:0] CH_HASH = 8'h23;
	localparam logic [7:0] CH_DOT = 8'h2E;
	localparam logic [7:0] CH_MINUS = 8'h2D;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] CH_WS_MAX = 8'h20;
	localparam logic [7:0] CH_LOW_A = 8'h61;
	localparam logic [7:0] CH_LOW_Z = 8'h7A;
	localparam logic [7:0] CASE_BIT = 8'h20;
	localparam logic [7:0] ASCII_MASK = 8'h7F;
	localparam logic [7:0] CH_XON = 8'h11;
	localparam logic [7:0] CH_XOFF = 8'h13;
	localparam logic signed [16:0] PT_MIN = 17'h1F800;
	localparam logic signed [16:0] PT_MAX = 17'h007FF;
	localparam logic signed [16:0] CH_FIRST = 17'h00001;
	localparam logic [7:0] CH_RESET = 8'h01;
	localparam logic [1:0] QERR_DEADLOCK = 2'h2;
	typedef struct packed {
		logic end_flag;
		logic [7:0] data;
	} in_byte_t;
	typedef struct packed {
		logic [15:0] index;
		logic [15:0] value;
	} point_t;
	typedef enum logic [1:0] {
		CLS_OTHER = 2'b00,
		CLS_SEL_CH = 2'b01,
		CLS_DEF_ASCII = 2'b10,
		CLS_DEF_BIN = 2'b11
	} cmd_class_t;
	typedef enum logic [3:0] {
		P_IDLE = 4'b0000,
		P_ID = 4'b0001,
		P_ARGS = 4'b0010,
		P_BNDIG = 4'b0011,
		P_BLEN = 4'b0100,
		P_BDATA = 4'b0101,
		P_EXEC = 4'b0110,
		P_RESP = 4'b0111,
		P_SKIP = 4'b1000
	} parse_state_t;
	typedef enum logic [1:0] {
		F_IDLE = 2'b00,
		F_BODY = 2'b01,
		F_CR = 2'b10,
		F_LF = 2'b11
	} fmt_state_t;
endpackage

/* rtl/remote_command_front_end.sv */
// Purpose: input queue, flow control, command splitter and response framer
// Assumes: link bytes, talk_en and executor signals are synchronous to clk
// Notes: command names are classified by an outside decoder from id_str
// Operation
// R1: Raw input bytes held in 256-byte queue
// R2: Serial: send XOFF at 200 queued bytes
// R3: Serial: send XON after 100 freed positions
// R4: Commands run in order, one at a time
// R5: Non-addressable serial: responses sent immediately
// R6: Addressable/parallel: wait for talk, then continue
// R7: Controller ends serial commands with 0AH
// R8: Semicolon 3BH separates commands in message
// R9: Serial responses end with CR then LF
// R10: Bytes 00H-20H are discarded white space
// R11: White space splits a command identifier
// R12: Parallel: 0AH is not white space
// R13: Drop bit 7, compare names case-blind
// R14: Parallel: NL, NL with END, END terminate
// R15: Parallel: response ends NL with END
// R16: Operation complete pulse after each execution
// R17: Numbers converted then rounded upward
// R18: Channel select 1..max steers later commands
// R19: ASCII points are signed -2048..+2047
// R20: Binary block: hash header, MSB-first pairs
// R21: Short data keeps old points, extra dropped
// R22: Length mismatch warns; edit limits reset
// R23: Binary definition refused on serial link
// R24: Queue full with pending response: deadlock error
// R25: Parsing starts only once terminator queued
`timescale 1ns/1ps
`default_nettype none
module byte_queue #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 256
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;
	// Depth must be a power of two so pointers wrap freely
	assign in_ready = cnt_r != (AW+1)'(DEPTH);
	assign out_valid = cnt_r != '0;
	assign out_data = mem[rd_r];
	assign level = cnt_r;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_r] <= in_data;
		end
	end
	// Pointers and fill level
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			wr_r <= wr_r + AW'(push);
			rd_r <= rd_r + AW'(pop);
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module remote_command_front_end
	import front_end_pkg::*;
#(
	parameter int DEPTH = front_end_pkg::QUEUE_DEPTH,
	parameter int ID_LEN = 12,
	parameter int MAX_CH = 4,
	parameter logic [31:0] ADDR_CTRL_MASK = 32'h00000000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic link_parallel,
	input wire logic addressable,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_end,
	output logic rx_ready,
	input wire logic talk_en,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_end,
	input wire logic tx_ready,
	output logic [8*ID_LEN-1:0] id_str,
	input wire front_end_pkg::cmd_class_t cmd_class,
	output logic arg_valid,
	output logic [7:0] arg_byte,
	output logic cmd_start,
	input wire logic cmd_done,
	output logic op_complete,
	input wire logic resp_valid_in,
	input wire logic [7:0] resp_data_in,
	input wire logic resp_last_in,
	output logic resp_ready_out,
	output logic [7:0] channel,
	input wire logic [15:0] exist_len,
	output logic wave_def_start,
	output logic [15:0] wave_len,
	output logic [15:0] edit_first,
	output logic [15:0] edit_last,
	output logic warn_len,
	output logic point_valid,
	output front_end_pkg::point_t point,
	output logic cmd_error,
	output logic exec_error,
	output logic query_error,
	output logic [1:0] query_code
);
	import front_end_pkg::*;
	localparam int LW = $clog2(DEPTH) + 1;
	parse_state_t state_r;
	fmt_state_t fmt_r;
	cmd_class_t cls_r;
	cmd_class_t exec_cls;
	in_byte_t q_in, q_out;
	logic q_valid, q_ready, q_in_ready, q_full, drop_ctl, pop;
	logic [LW-1:0] level, term_cnt_r;
	logic [7:0] c, up;
	logic ws, sep, endm, digit, end_pend_r, leave_id, to_exec, refuse;
	logic [3:0] dval, ndig_r;
	logic [15:0] arg_idx_r, num_r, num_w, blen_r, bidx_r;
	logic have_r, neg_r, frac_r, rup_r, have_w, neg_w, frac_w, rup_w;
	logic phase_r, field_end;
	logic [7:0] hi_r;
	logic [16:0] mag;
	logic signed [16:0] sval;
	logic can_send, need_xoff, need_xon, fc_sel, body_sel, xoff_sent_r;
	logic drop_r, deadlock, fmt_busy;

	function automatic logic is_term(input logic par, input in_byte_t b);
		is_term = ((b.data & ASCII_MASK) == CH_LF) || (par && b.end_flag);
	endfunction

	// Addressable control codes on the serial link never reach the parser
	assign drop_ctl = !link_parallel && addressable && rx_data[6:5] == 2'b00
		&& ADDR_CTRL_MASK[rx_data[4:0]]; // R10
	assign q_in = '{end_flag: rx_end, data: rx_data};
	assign rx_ready = q_in_ready || drop_ctl;
	assign q_full = !q_in_ready;

	byte_queue #(.WIDTH($bits(in_byte_t)), .DEPTH(DEPTH)) u_queue ( // R1
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(rx_valid && !drop_ctl),
		.in_ready(q_in_ready),
		.in_data(q_in),
		.out_valid(q_valid),
		.out_ready(q_ready),
		.out_data(q_out),
		.level(level)
	);

	// Byte classification of the queue head
	always_comb begin
		c = q_out.data & ASCII_MASK; // R13
		up = (c >= CH_LOW_A && c <= CH_LOW_Z) ? (c & ~CASE_BIT) : c; // R13
		ws = (c <= CH_WS_MAX) && !(link_parallel && c == CH_LF); // R10 R12
		sep = c == CH_SEMI; // R8
		endm = is_term(link_parallel, q_out); // R14
		digit = c >= CH_ZERO && c <= CH_NINE;
		dval = c[3:0];
	end

	// Only pull bytes when a whole message is queued, so nothing half-sent runs
	always_comb begin
		case (state_r)
			P_IDLE: q_ready = term_cnt_r != '0; // R25
			P_ID: q_ready = !end_pend_r;
			P_ARGS, P_BNDIG, P_BLEN, P_BDATA, P_SKIP: q_ready = 1'b1;
			default: q_ready = 1'b0;
		endcase
	end
	assign pop = q_ready && q_valid;
	// A letter carrying END is kept and ends the name one cycle later
	assign leave_id = state_r == P_ID && (end_pend_r || (pop && (ws || sep || c == CH_LF)));
	assign refuse = leave_id && cmd_class == CLS_DEF_BIN && !link_parallel; // R23
	assign exec_cls = (state_r == P_ID) ? cmd_class : cls_r;
	assign to_exec = (leave_id && !refuse && (end_pend_r || sep || endm))
		|| (state_r == P_ARGS && pop && (sep || endm));

	// Queued terminator count; binary 0AH is counted on both sides alike
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			term_cnt_r <= '0;
		end else begin
			term_cnt_r <= term_cnt_r
				+ LW'(rx_valid && q_in_ready && !drop_ctl && is_term(link_parallel, q_in))
				- LW'(pop && endm); // R25
		end
	end

	// Parser sequencing; one command at a time
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= P_IDLE;
			cls_r <= CLS_OTHER;
			id_str <= '0;
			end_pend_r <= 1'b0;
		end else begin
			case (state_r)
				P_IDLE: if (pop && !ws && !sep && c != CH_LF) begin
					id_str <= {{(8*ID_LEN-8){1'b0}}, up};
					end_pend_r <= endm;
					state_r <= P_ID;
				end
				P_ID: begin
					if (leave_id) begin
						cls_r <= cmd_class;
						end_pend_r <= 1'b0;
						if (refuse) begin
							state_r <= (end_pend_r || sep || endm) ? P_IDLE : P_SKIP;
						end else begin
							state_r <= to_exec ? P_EXEC : P_ARGS; // R11
						end
					end else if (pop) begin
						id_str <= {id_str[8*ID_LEN-9:0], up};
						end_pend_r <= endm;
					end
				end
				P_ARGS: if (to_exec) begin
					state_r <= P_EXEC;
				end else if (pop && cls_r == CLS_DEF_BIN && arg_idx_r == 16'h0002 && c == CH_HASH) begin
					state_r <= P_BNDIG; // R20
				end
				P_BNDIG: if (pop) begin
					if (digit && dval != 4'h0) begin
						state_r <= P_BLEN;
					end else begin
						state_r <= (sep || endm) ? P_IDLE : P_SKIP;
					end
				end
				P_BLEN: if (pop) begin
					if (!digit) begin
						state_r <= (sep || endm) ? P_IDLE : P_SKIP;
					end else if (ndig_r == 4'h1) begin
						state_r <= (16'(blen_r * 16'h000A + {12'h000, dval}) == '0) ? P_ARGS : P_BDATA;
					end
				end
				P_BDATA: if (pop && blen_r == 16'h0001) begin
					state_r <= (link_parallel && q_out.end_flag) ? P_EXEC : P_ARGS; // R14
				end
				P_SKIP: if (pop && (sep || endm)) begin
					state_r <= P_IDLE;
				end
				P_EXEC: if (cls_r != CLS_OTHER || cmd_done) begin
					state_r <= P_RESP; // R4 R16
				end
				P_RESP: if (!fmt_busy && !resp_valid_in && !drop_r) begin
					state_r <= P_IDLE; // R4 R6
				end
				default: state_r <= P_IDLE;
			endcase
		end
	end

	// Number scan, fractional digits only decide the upward rounding
	always_comb begin
		num_w = num_r;
		have_w = have_r;
		neg_w = neg_r;
		frac_w = frac_r;
		rup_w = rup_r;
		if (digit) begin
			have_w = 1'b1;
			if (frac_r) begin
				rup_w = rup_r || dval != 4'h0; // R17
			end else begin
				num_w = 16'(num_r * 16'h000A + {12'h000, dval});
			end
		end else if (c == CH_MINUS) begin
			neg_w = 1'b1;
		end else if (c == CH_DOT) begin
			frac_w = 1'b1;
		end
		// Rounding up moves toward plus, so a negative value only truncates
		mag = {1'b0, num_w} + {16'h0000, rup_w && !neg_w}; // R17
		sval = neg_w ? -$signed(mag) : $signed(mag);
	end
	assign field_end = state_r == P_ARGS && pop && (c == CH_COMMA || sep || endm)
		&& have_w && cls_r != CLS_OTHER;

	// Argument fields and binary block counters
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			arg_idx_r <= '0;
			{num_r, have_r, neg_r, frac_r, rup_r} <= '0;
			{ndig_r, blen_r, bidx_r, phase_r, hi_r} <= '0;
		end else if (leave_id) begin
			arg_idx_r <= '0;
			{num_r, have_r, neg_r, frac_r, rup_r} <= '0;
		end else if (pop) begin
			case (state_r)
				P_ARGS: if (c == CH_COMMA || sep || endm) begin
					arg_idx_r <= arg_idx_r + 16'h0001;
					{num_r, have_r, neg_r, frac_r, rup_r} <= '0;
				end else if (!ws) begin
					{num_r, have_r, neg_r, frac_r, rup_r} <= {num_w, have_w, neg_w, frac_w, rup_w};
				end
				P_BNDIG: begin
					ndig_r <= dval;
					blen_r <= '0;
				end
				P_BLEN: begin
					ndig_r <= ndig_r - 4'h1;
					blen_r <= 16'(blen_r * 16'h000A + {12'h000, dval});
					bidx_r <= '0;
					phase_r <= 1'b0;
					arg_idx_r <= 16'h0003;
				end
				P_BDATA: begin
					blen_r <= blen_r - 16'h0001;
					phase_r <= !phase_r;
					hi_r <= q_out.data; // R20
					bidx_r <= bidx_r + 16'(phase_r);
				end
				default: arg_idx_r <= arg_idx_r;
			endcase
		end
	end

	// Channel, waveform definition and point writes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			channel <= CH_RESET;
			{wave_len, edit_first, edit_last, point} <= '0;
			{wave_def_start, warn_len, point_valid, exec_error} <= '0;
		end else begin
			{wave_def_start, warn_len, point_valid, exec_error} <= '0;
			if (field_end && cls_r == CLS_SEL_CH && arg_idx_r == '0) begin
				if (sval >= CH_FIRST && sval <= $signed(17'(MAX_CH))) begin
					channel <= sval[7:0]; // R18
				end else begin
					exec_error <= 1'b1;
				end
			end else if (field_end && cls_r != CLS_SEL_CH && arg_idx_r == 16'h0001) begin
				wave_len <= sval[15:0];
				wave_def_start <= 1'b1;
				warn_len <= exist_len != '0 && exist_len != sval[15:0]; // R22
				edit_first <= '0; // R22
				edit_last <= sval[15:0] - 16'h0001;
			end else if (field_end && cls_r == CLS_DEF_ASCII && arg_idx_r >= 16'h0002) begin
				if (sval < PT_MIN || sval > PT_MAX) begin
					exec_error <= 1'b1; // R19
				end else if (arg_idx_r - 16'h0002 < wave_len) begin
					point_valid <= 1'b1; // R21
					point <= '{index: arg_idx_r - 16'h0002, value: sval[15:0]};
				end
			end else if (state_r == P_BDATA && pop && phase_r && bidx_r < wave_len) begin
				point_valid <= 1'b1; // R20 R21
				point <= '{index: bidx_r, value: {hi_r, q_out.data}};
			end
		end
	end

	// Command strobes and parse errors
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{cmd_start, op_complete, cmd_error, arg_valid, arg_byte} <= '0;
		end else begin
			cmd_start <= to_exec && exec_cls == CLS_OTHER;
			op_complete <= state_r == P_EXEC && (cls_r != CLS_OTHER || cmd_done); // R16
			cmd_error <= refuse || (pop && (state_r == P_BNDIG || state_r == P_BLEN)
				&& (!digit || (state_r == P_BNDIG && dval == 4'h0))); // R23
			arg_valid <= state_r == P_ARGS && pop && cls_r == CLS_OTHER && !ws
				&& !sep && c != CH_LF;
			arg_byte <= up;
		end
	end

	// Output mux: flow control beats response bytes on the serial line
	assign can_send = (!link_parallel && !addressable) || talk_en; // R5 R6
	assign need_xoff = !link_parallel && !xoff_sent_r && 32'(level) >= XOFF_LEVEL; // R2
	assign need_xon = xoff_sent_r && 32'(level) <= XON_LEVEL; // R3
	always_comb begin
		{tx_valid, tx_data, tx_end, fc_sel, body_sel} = '0;
		if (need_xoff || need_xon) begin
			tx_valid = 1'b1;
			tx_data = need_xoff ? CH_XOFF : CH_XON;
			fc_sel = 1'b1;
		end else if (can_send) begin
			case (fmt_r)
				F_IDLE, F_BODY: begin
					body_sel = resp_valid_in && !drop_r;
					tx_valid = body_sel;
					tx_data = resp_data_in;
				end
				F_CR: begin
					tx_valid = 1'b1;
					tx_data = CH_CR; // R9
				end
				F_LF: begin
					tx_valid = 1'b1;
					tx_data = CH_LF; // R9 R15
					tx_end = link_parallel; // R15
				end
				default: tx_valid = 1'b0;
			endcase
		end
	end
	assign resp_ready_out = drop_r || (body_sel && tx_ready);
	assign fmt_busy = fmt_r != F_IDLE;
	assign deadlock = (fmt_busy || (resp_valid_in && !drop_r)) && q_full && !can_send; // R24

	// Flow control memory
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			xoff_sent_r <= 1'b0;
		end else if (fc_sel && tx_ready) begin
			xoff_sent_r <= need_xoff; // R2 R3
		end
	end

	// Response framing; a deadlock discards the rest of the response
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fmt_r <= F_IDLE;
			{drop_r, query_error, query_code} <= '0;
		end else begin
			query_error <= deadlock; // R24
			if (deadlock) begin
				query_code <= QERR_DEADLOCK;
				fmt_r <= F_IDLE;
				drop_r <= fmt_r == F_BODY || fmt_r == F_IDLE;
			end else begin
				if (drop_r && resp_valid_in && resp_last_in) begin
					drop_r <= 1'b0;
				end
				if (body_sel && tx_ready) begin
					fmt_r <= !resp_last_in ? F_BODY : (link_parallel ? F_LF : F_CR);
				end else if (tx_valid && !fc_sel && tx_ready && fmt_r == F_CR) begin
					fmt_r <= F_LF;
				end else if (tx_valid && !fc_sel && tx_ready && fmt_r == F_LF) begin
					fmt_r <= F_IDLE;
				end
			end
		end
	end

	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_xoff_level: assert property (fc_sel && need_xoff |-> 32'(level) >= XOFF_LEVEL) // R2
		else $error("xoff below level");
	chk_xon_after: assert property (fc_sel && tx_data == CH_XON |-> xoff_sent_r && 32'(level) <= XON_LEVEL) // R3
		else $error("xon without xoff");
	chk_start_term: assert property (state_r == P_IDLE && pop |-> term_cnt_r != '0) // R25
		else $error("parse before terminator");
	chk_talk_wait: assert property (body_sel && (addressable || link_parallel) |-> talk_en) // R6
		else $error("sent without talk");
	chk_serial_trailer: assert property (fmt_r == F_CR && tx_valid && !fc_sel && tx_ready && !deadlock
		|=> fmt_r == F_LF) // R9
		else $error("cr not followed by lf");
	chk_par_end: assert property (tx_end |-> link_parallel && tx_data == CH_LF) // R15
		else $error("end without newline");
	chk_bin_refuse: assert property (refuse |=> cmd_error && state_r != P_EXEC) // R23
		else $error("binary not refused");
	chk_point_range: assert property (point_valid |-> point.index < wave_len) // R21
		else $error("point beyond length");
	chk_deadlock_reset: assert property (deadlock |=> query_error && query_code == QERR_DEADLOCK && !fmt_busy) // R24
		else $error("deadlock not handled");
	chk_opc_exec: assert property (op_complete |-> $past(state_r) == P_EXEC && state_r == P_RESP) // R16
		else $error("opc outside execution");
	chk_one_cmd: assert property (cmd_start |-> state_r == P_EXEC) // R4
		else $error("start outside execution");
	chk_channel_range: assert property (channel >= 8'h01 && 32'(channel) <= MAX_CH) // R18
		else $error("channel out of range");
endmodule
`default_nettype wire
